// ### rtl/fpag_pkg.sv
// Constants and types shared by the flash program access gate
package fpag_pkg;
	localparam int ROW_BYTES = 32;
	localparam int IDX_W = 5;
	localparam int ROW_W = 8;
	localparam int RAM_AW = 10;
	localparam logic [7:0] ENTRY_KEY = 8'ha5;
	localparam logic [1:0] STRAP_SAMPLE = 2'h2;
	localparam logic [IDX_W-1:0] LAST_IDX = 5'h1f;
	localparam logic [RAM_AW-1:0] RAM_BASE = 10'h000;
	typedef enum logic [1:0] {
		FPAG_CTX_USER = 2'b00,
		FPAG_CTX_SOCKET = 2'b01,
		FPAG_CTX_ICP = 2'b10,
		FPAG_CTX_IAP = 2'b11
	} fpag_ctx_t;
	typedef enum logic [1:0] {
		FPAG_AREA_SECTOR0 = 2'b00,
		FPAG_AREA_SECTOR1 = 2'b01,
		FPAG_AREA_OPTION = 2'b10,
		FPAG_AREA_EEPROM = 2'b11
	} fpag_area_t;
	typedef enum logic [1:0] {
		FPAG_OP_LATCH = 2'b00,
		FPAG_OP_COMMIT = 2'b01,
		FPAG_OP_ERASE = 2'b10,
		FPAG_OP_NONE = 2'b11
	} fpag_op_t;
	typedef enum logic [1:0] {
		FPAG_ST_IDLE = 2'b00,
		FPAG_ST_SCAN = 2'b01,
		FPAG_ST_DRAIN = 2'b10
	} fpag_state_t;
endpackage

// ### rtl/fpag_latch_mem.sv
// Row of write latches with a registered read port
`timescale 1ns/100ps
module fpag_latch_mem (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [fpag_pkg::IDX_W-1:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [fpag_pkg::IDX_W-1:0] rd_idx,
	output logic [7:0] rd_data_q
);
	import fpag_pkg::*;
	logic [7:0] mem [ROW_BYTES];

	// Storage, no reset needed; a mask outside says which bytes are live
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		rd_data_q <= mem[rd_idx];
	end
endmodule // fpag_latch_mem

// ### rtl/fpag_gate.sv
// Flash program access gate: context latch, link entry, permission check, row commit
`timescale 1ns/100ps
// Overview of operation
// R1: Flash writes are done one byte at a time or as a row of up to 32 latched bytes.
// R2: An erase touches only the one sector named in the request.
// R3: In socket or in-circuit context sector 0, sector 1, option row and EEPROM are writable.
// R4: In in-application context sector 0 and the option row are refused.
// R5: In-application work runs with the user code, with no reset needed.
// R6: A key on the link while reset is low enters comm mode and selects the boot vector.
// R7: In comm mode link bytes are stored into RAM one after another.
// R8: The tool alone owns reset during a session; nothing else may assert it.
// R9: Link clock is the serial clock, link data the serial input, select gates the link.
// R10: The context is latched once at entry and held until the next reset.
module fpag_gate (
	input wire logic clk,
	input wire logic rst,
	input wire logic prog_link_clock,
	input wire logic prog_link_data,
	input wire logic prog_link_select,
	input wire logic reset_pin_n,
	input wire logic socket_strap,
	input wire logic iap_enter,
	input wire logic req_valid,
	input wire fpag_pkg::fpag_op_t req_op,
	input wire fpag_pkg::fpag_area_t req_area,
	input wire logic [fpag_pkg::ROW_W-1:0] req_row,
	input wire logic [fpag_pkg::IDX_W-1:0] req_idx,
	input wire logic [7:0] req_data,
	output fpag_pkg::fpag_ctx_t ctx_q,
	output logic serial_prog_comm_mode_q,
	output logic boot_vector_sel_q,
	output logic req_ack_q,
	output logic req_deny_q,
	output logic busy_q,
	output logic flash_wr_valid_q,
	output fpag_pkg::fpag_area_t flash_area_q,
	output logic [fpag_pkg::ROW_W-1:0] flash_row_q,
	output logic [fpag_pkg::IDX_W-1:0] flash_idx_q,
	output logic [7:0] flash_data_q,
	output logic flash_erase_q,
	output logic ram_wr_valid_q,
	output logic [fpag_pkg::RAM_AW-1:0] ram_wr_addr_q,
	output logic [7:0] ram_wr_data_q
);
	import fpag_pkg::*;

	// Link domain
	logic [7:0] key_sr_q;
	logic key_tgl_q;
	logic comm_l1_q, comm_l2_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] byte_sr_q;
	logic [7:0] byte_hold_q;
	logic byte_tgl_q;

	// R9: link pins serve as serial clock and data input
	// Key search until comm mode is seen in this domain
	always_ff @(posedge prog_link_clock or posedge rst) begin
		if (rst) begin
			key_sr_q <= 8'h00;
			key_tgl_q <= 1'b0;
		end else if (prog_link_select && !comm_l2_q) begin
			key_sr_q <= {key_sr_q[6:0], prog_link_data};
			if ({key_sr_q[6:0], prog_link_data} == ENTRY_KEY) begin
				key_tgl_q <= ~key_tgl_q;
			end
		end
	end

	// Comm mode level brought over to the link side
	always_ff @(posedge prog_link_clock or posedge rst) begin
		if (rst) begin
			comm_l1_q <= 1'b0;
			comm_l2_q <= 1'b0;
		end else begin
			comm_l1_q <= serial_prog_comm_mode_q;
			comm_l2_q <= comm_l1_q;
		end
	end

	// R7: byte framing, MSB first; held byte stays put for eight link clocks
	always_ff @(posedge prog_link_clock or posedge rst) begin
		if (rst) begin
			bit_cnt_q <= 3'h0;
			byte_sr_q <= 7'h00;
			byte_hold_q <= 8'h00;
			byte_tgl_q <= 1'b0;
		end else if (prog_link_select && comm_l2_q) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			byte_sr_q <= {byte_sr_q[5:0], prog_link_data};
			if (bit_cnt_q == 3'h7) begin
				byte_hold_q <= {byte_sr_q, prog_link_data};
				byte_tgl_q <= ~byte_tgl_q;
			end
		end
	end

	// System domain synchronisers
	logic [2:0] key_sync_q, byte_sync_q;
	logic [1:0] rstpin_sync_q, strap_sync_q;
	logic key_evt, byte_evt, rstpin_low;

	// Toggles and pins through two flops; third flop only for edge detect
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_sync_q <= 3'h0;
			byte_sync_q <= 3'h0;
			rstpin_sync_q <= 2'h3;
			strap_sync_q <= 2'h0;
		end else begin
			key_sync_q <= {key_sync_q[1:0], key_tgl_q};
			byte_sync_q <= {byte_sync_q[1:0], byte_tgl_q};
			rstpin_sync_q <= {rstpin_sync_q[0], reset_pin_n};
			strap_sync_q <= {strap_sync_q[0], socket_strap};
		end
	end
	assign key_evt = key_sync_q[2] ^ key_sync_q[1];
	assign byte_evt = byte_sync_q[2] ^ byte_sync_q[1];
	assign rstpin_low = ~rstpin_sync_q[1];

	// Strap is sampled once, after reset release and the sync delay
	logic [1:0] strap_cnt_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_cnt_q <= 2'h0;
		end else if (strap_cnt_q != 2'h3) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end
	end

	// Strap wins over a key in the same cycle; comm mode must follow the same choice
	logic strap_hit, enter_icp;
	assign strap_hit = strap_cnt_q == STRAP_SAMPLE && strap_sync_q[1];
	assign enter_icp = ctx_q == FPAG_CTX_USER && !strap_hit && key_evt && rstpin_low;

	// R10: context latched once, held until reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctx_q <= FPAG_CTX_USER;
		end else if (ctx_q == FPAG_CTX_USER) begin
			if (strap_hit) begin
				ctx_q <= FPAG_CTX_SOCKET;
			end else if (enter_icp) begin
				ctx_q <= FPAG_CTX_ICP;
			end else if (iap_enter) begin
				// R5: entered by running code, no reset involved
				ctx_q <= FPAG_CTX_IAP;
			end
		end
	end

	// R6: key seen under reset enters comm mode and picks the boot vector
	// R8: a later reset is assumed to come from the tool and ends nothing here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_prog_comm_mode_q <= 1'b0;
			boot_vector_sel_q <= 1'b0;
		end else if (enter_icp) begin
			serial_prog_comm_mode_q <= 1'b1;
			boot_vector_sel_q <= 1'b1;
		end
	end

	// R7: received bytes go to RAM at rising addresses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_wr_valid_q <= 1'b0;
			ram_wr_addr_q <= RAM_BASE;
			ram_wr_data_q <= 8'h00;
		end else begin
			ram_wr_valid_q <= byte_evt && serial_prog_comm_mode_q;
			if (ram_wr_valid_q) begin
				ram_wr_addr_q <= ram_wr_addr_q + 10'h001;
			end
			if (byte_evt) begin
				ram_wr_data_q <= byte_hold_q;
			end
		end
	end

	// R3 R4: area permission per context
	function automatic logic area_ok(fpag_ctx_t c, fpag_area_t a);
		unique case (c)
			FPAG_CTX_SOCKET, FPAG_CTX_ICP: area_ok = 1'b1;
			FPAG_CTX_IAP: area_ok = (a == FPAG_AREA_SECTOR1) || (a == FPAG_AREA_EEPROM);
			FPAG_CTX_USER: area_ok = 1'b0;
		endcase
	endfunction

	logic take, ok;
	fpag_state_t state_q;
	logic [ROW_BYTES-1:0] mask_q;
	logic [IDX_W-1:0] scan_idx_q, p1_idx_q;
	logic p1_vld_q, p2_vld_q;
	logic [IDX_W-1:0] p2_idx_q;
	logic [7:0] rd_data;
	assign take = req_valid && !busy_q && req_op != FPAG_OP_NONE;
	assign ok = area_ok(ctx_q, req_area) || req_op == FPAG_OP_LATCH;

	// Answer: one pulse the cycle after a request is taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_ack_q <= 1'b0;
			req_deny_q <= 1'b0;
		end else begin
			req_ack_q <= take && ok;
			// R4: refused areas answer with deny
			req_deny_q <= take && !ok;
		end
	end

	// R1: latch up to 32 bytes; commit sends only live bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= FPAG_ST_IDLE;
			busy_q <= 1'b0;
			mask_q <= '0;
			scan_idx_q <= '0;
			flash_area_q <= FPAG_AREA_SECTOR0;
			flash_row_q <= '0;
		end else begin
			unique case (state_q)
				FPAG_ST_IDLE: begin
					if (take && req_op == FPAG_OP_LATCH) begin
						mask_q[req_idx] <= 1'b1;
					end else if (take && ok && req_op == FPAG_OP_COMMIT) begin
						state_q <= FPAG_ST_SCAN;
						busy_q <= 1'b1;
						scan_idx_q <= '0;
						flash_area_q <= req_area;
						flash_row_q <= req_row;
					end else if (take && ok && req_op == FPAG_OP_ERASE) begin
						flash_area_q <= req_area;
					end
				end
				FPAG_ST_SCAN: begin
					scan_idx_q <= scan_idx_q + 5'h01;
					if (scan_idx_q == LAST_IDX) begin
						state_q <= FPAG_ST_DRAIN;
					end
				end
				FPAG_ST_DRAIN: begin
					if (!p1_vld_q && !p2_vld_q) begin
						state_q <= FPAG_ST_IDLE;
						busy_q <= 1'b0;
						mask_q <= '0;
					end
				end
				default: state_q <= FPAG_ST_IDLE;
			endcase
		end
	end

	fpag_latch_mem u_latch (
		.clk(clk),
		.wr_en(take && req_op == FPAG_OP_LATCH),
		.wr_idx(req_idx),
		.wr_data(req_data),
		.rd_idx(scan_idx_q),
		.rd_data_q(rd_data)
	);

	// Two-stage pipe matches the registered latch read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p1_vld_q <= 1'b0;
			p1_idx_q <= '0;
			p2_vld_q <= 1'b0;
			p2_idx_q <= '0;
		end else begin
			p1_vld_q <= state_q == FPAG_ST_SCAN && mask_q[scan_idx_q];
			p1_idx_q <= scan_idx_q;
			p2_vld_q <= p1_vld_q;
			p2_idx_q <= p1_idx_q;
		end
	end

	// R2: erase pulse names one sector only; program strobe per byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_wr_valid_q <= 1'b0;
			flash_idx_q <= '0;
			flash_data_q <= 8'h00;
			flash_erase_q <= 1'b0;
		end else begin
			flash_wr_valid_q <= p1_vld_q;
			flash_idx_q <= p1_idx_q;
			flash_data_q <= rd_data;
			flash_erase_q <= take && ok && req_op == FPAG_OP_ERASE;
		end
	end

	// R4: sector 0 refused in application context
	a_iap_sector0: assert property (@(posedge clk) disable iff (rst) // R4
		(req_valid && !busy_q && ctx_q == FPAG_CTX_IAP && req_area == FPAG_AREA_SECTOR0
		 && req_op == FPAG_OP_ERASE) |=> req_deny_q && !req_ack_q && !flash_erase_q)
		else $error("sector 0 erase not refused in application context");
	// R3: in-circuit context grants sector 0 erase
	a_icp_grant: assert property (@(posedge clk) disable iff (rst) // R3
		(take && ctx_q == FPAG_CTX_ICP && req_op == FPAG_OP_ERASE) |=> req_ack_q && flash_erase_q)
		else $error("in-circuit erase not granted");
	// R10: context stable once left user
	a_ctx_hold: assert property (@(posedge clk) disable iff (rst) // R10
		($past(ctx_q) != FPAG_CTX_USER) |-> ctx_q == $past(ctx_q))
		else $error("context changed after entry");
	// R6: comm mode only via in-circuit context
	a_comm_ctx: assert property (@(posedge clk) disable iff (rst) // R6
		$rose(serial_prog_comm_mode_q) |-> ctx_q == FPAG_CTX_ICP && boot_vector_sel_q)
		else $error("comm mode without in-circuit entry");
	// R7: byte reaches RAM one cycle after its event
	a_byte_ram: assert property (@(posedge clk) disable iff (rst) // R7
		(byte_evt && serial_prog_comm_mode_q) |=> ram_wr_valid_q ##1 !ram_wr_valid_q[*1])
		else $error("link byte not written to RAM");
	// R1: commit completes within a bounded time
	a_commit_end: assert property (@(posedge clk) disable iff (rst) // R1
		$rose(busy_q) |-> ##[34:36] !busy_q)
		else $error("row commit did not finish in time");
	// R1: program strobes only while committing
	a_wr_busy: assert property (@(posedge clk) disable iff (rst) // R1
		flash_wr_valid_q |-> busy_q)
		else $error("flash write outside a commit");
	// R2: erase strobe only for a granted request, naming that one sector
	a_erase_pulse: assert property (@(posedge clk) disable iff (rst) // R2
		flash_erase_q |-> $past(take && ok && req_op == FPAG_OP_ERASE)
		&& flash_area_q == $past(req_area))
		else $error("erase strobe without a matching granted request");
	// R5: application context leaves comm mode off
	a_iap_nocomm: assert property (@(posedge clk) disable iff (rst) // R5
		(ctx_q == FPAG_CTX_IAP) |-> !serial_prog_comm_mode_q)
		else $error("comm mode in application context");
endmodule // fpag_gate

// ### sim/fpag_tool.sv
// Programming tool model: owns the reset pin and drives the serial link
`timescale 1ns/100ps
module fpag_tool (
	output logic lclk,
	output logic ldata,
	output logic lsel,
	output logic rstn
);
	initial begin
		lclk = 1'b0;
		ldata = 1'b1;
		lsel = 1'b0;
		rstn = 1'b1;
	end
	// session reset held by tool alone
	task hold_reset(input logic on);
		rstn = !on;
	endtask
	// clock only in frames, data MSB first
	task byte_out(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			lsel = 1'b1;
			ldata = b[i];
			#4 lclk = 1'b1;
			#7.5 lclk = 1'b0;
			#3.5;
		end
		// Idle data flips so a stale bit cannot pass as valid
		ldata = !b[0];
	endtask
	// bare link clocks with select as given; data left as it stands
	task clocks(input int n, input logic sel);
		lsel = sel;
		repeat (n) begin
			#4 lclk = 1'b1;
			#7.5 lclk = 1'b0;
			#3.5;
		end
	endtask
endmodule // fpag_tool

// ### sim/tb.sv
// Self-checking bench of the flash program access gate
`timescale 1ns/100ps
module tb;
	import fpag_pkg::*;
	logic clk, rst, lclk, ldata, lsel, rstn, strap, in_application_programming, req_valid;
	fpag_op_t op;
	fpag_area_t area, f_area;
	fpag_ctx_t ctx;
	logic [7:0] row, data, f_row, f_data, r_data, seed;
	logic [4:0] idx, f_idx;
	logic [9:0] r_addr;
	logic comm, bootv, ack, deny, busy, f_wr, f_er, r_wr, a, d;
	logic [7:0] exp_d [32];
	logic exp_v [32];
	logic [22:0] fq [$];
	logic [17:0] rq [$];
	logic [1:0] eq [$];
	logic [31:0] rnd;
	int error_cnt, checked, k;
	fpag_tool u_tool (.lclk(lclk), .ldata(ldata), .lsel(lsel), .rstn(rstn));
	fpag_gate u_dut (.clk(clk), .rst(rst), .prog_link_clock(lclk), .prog_link_data(ldata),
		.prog_link_select(lsel), .reset_pin_n(rstn), .socket_strap(strap), .iap_enter(in_application_programming),
		.req_valid(req_valid), .req_op(op), .req_area(area), .req_row(row), .req_idx(idx),
		.req_data(data), .ctx_q(ctx), .serial_prog_comm_mode_q(comm), .boot_vector_sel_q(bootv),
		.req_ack_q(ack), .req_deny_q(deny), .busy_q(busy), .flash_wr_valid_q(f_wr),
		.flash_area_q(f_area), .flash_row_q(f_row), .flash_idx_q(f_idx), .flash_data_q(f_data),
		.flash_erase_q(f_er), .ram_wr_valid_q(r_wr), .ram_wr_addr_q(r_addr),
		.ram_wr_data_q(r_data));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	// Record every flash, erase and RAM strobe
	always @(posedge clk) begin
		if (f_wr === 1'b1) fq.push_back({f_area, f_row, f_idx, f_data});
		if (f_er === 1'b1) eq.push_back(f_area);
		if (r_wr === 1'b1) rq.push_back({r_addr, r_data});
	end
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Which areas a context may change
	function logic allowed(input fpag_ctx_t c, input fpag_area_t ar);
		if (c == FPAG_CTX_SOCKET || c == FPAG_CTX_ICP) return 1'b1;
		if (c == FPAG_CTX_IAP) return ar == FPAG_AREA_SECTOR1 || ar == FPAG_AREA_EEPROM;
		return 1'b0;
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g) begin
			$display("mismatch %s exp %h got %h", n, e, g);
			error_cnt++;
		end
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task reset(input logic s);
		@(posedge clk) #1;
		strap = s;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask
	// One request, then note which answer came back
	task req(input fpag_op_t o, input fpag_area_t ar, input logic [4:0] i, input logic [7:0] v);
		@(posedge clk) #1 req_valid = 1'b1;
		op = o;
		area = ar;
		idx = i;
		data = v;
		@(posedge clk) #1 req_valid = 1'b0;
		a = 1'b0;
		d = 1'b0;
		repeat (3) begin
			if (ack === 1'b1) a = 1'b1;
			if (deny === 1'b1) d = 1'b1;
			@(posedge clk) #1;
		end
	endtask
	// Erase each area and check the answer against the context
	task erase_all(input fpag_ctx_t c);
		for (int n = 0; n < 4; n++) begin
			eq.delete();
			req(FPAG_OP_ERASE, fpag_area_t'(n), 5'h00, 8'h00);
			chk("ack", allowed(c, fpag_area_t'(n)), a);
			chk("deny", !allowed(c, fpag_area_t'(n)), d);
			chk("erases", allowed(c, fpag_area_t'(n)), eq.size());
			if (eq.size() > 0) chk("erase area", n, eq[0]);
		end
	endtask
	initial begin
		rst = 1'b1;
		{strap, in_application_programming, req_valid, row, idx, data} = '0;
		op = FPAG_OP_NONE;
		area = FPAG_AREA_SECTOR0;
		rnd = 32'he38a;
		reset(1'b0);
		chk("ctx user", FPAG_CTX_USER, ctx);
		erase_all(FPAG_CTX_USER);
		// In-application entry while user code runs
		in_application_programming = 1'b1;
		@(posedge clk) #1 in_application_programming = 1'b0;
		repeat (3) @(posedge clk);
		chk("ctx iap", FPAG_CTX_IAP, ctx);
		erase_all(FPAG_CTX_IAP);
		// Row fill with edges of the index range and one overwrite
		for (k = 0; k < 32; k++) exp_v[k] = 1'b0;
		for (k = 0; k < 9; k++) begin
			rnd = lfsr(rnd);
			idx = (k == 0) ? 5'h00 : (k == 1) ? LAST_IDX : (k == 8) ? 5'h00 : rnd[4:0];
			exp_v[idx] = 1'b1;
			exp_d[idx] = rnd[15:8];
			req(FPAG_OP_LATCH, FPAG_AREA_SECTOR1, idx, rnd[15:8]);
			chk("latch ack", 1, a);
		end
		row = rnd[23:16];
		fq.delete();
		eq.delete();
		req(FPAG_OP_COMMIT, FPAG_AREA_SECTOR1, 5'h00, 8'h00);
		chk("commit ack", 1, a);
		req(FPAG_OP_ERASE, FPAG_AREA_EEPROM, 5'h00, 8'h00);
		for (k = 0; k < 100 && busy === 1'b1; k++) @(posedge clk);
		repeat (3) @(posedge clk);
		chk("busy", 0, busy);
		chk("erase in busy", 0, eq.size());
		for (k = 0; k < 32; k++) begin
			if (exp_v[k]) begin
				chk("flash wr", {FPAG_AREA_SECTOR1, row, k[4:0], exp_d[k]}, fq.pop_front());
			end
		end
		chk("extra wr", 0, fq.size());
		// Denied commit of sector 0 leaves flash alone
		req(FPAG_OP_COMMIT, FPAG_AREA_SECTOR0, 5'h00, 8'h00);
		chk("s0 deny", 1, d);
		repeat (40) @(posedge clk);
		chk("s0 writes", 0, fq.size());
		// Link entry while the tool holds reset
		reset(1'b0);
		u_tool.hold_reset(1'b1);
		u_tool.byte_out(ENTRY_KEY);
		repeat (10) @(posedge clk);
		#1;
		chk("comm", 1, comm);
		chk("boot", 1, bootv);
		chk("ctx icp", FPAG_CTX_ICP, ctx);
		// Two link clocks carry comm mode over; byte framing starts on the next one
		u_tool.clocks(2, 1'b1);
		rq.delete();
		for (k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			seed = rnd[7:0];
			u_tool.byte_out(seed);
			repeat (8) @(posedge clk);
			#1;
			chk("ram", {RAM_BASE + k[9:0], seed}, rq.pop_front());
		end
		// Link clocks with select low must not frame a byte
		u_tool.clocks(8, 1'b0);
		repeat (8) @(posedge clk);
		#1;
		chk("sel low", 0, rq.size());
		in_application_programming = 1'b1;
		@(posedge clk) #1 in_application_programming = 1'b0;
		repeat (3) @(posedge clk);
		chk("ctx held", FPAG_CTX_ICP, ctx);
		erase_all(FPAG_CTX_ICP);
		u_tool.hold_reset(1'b0);
		// Socket strap at start-up
		reset(1'b1);
		chk("ctx socket", FPAG_CTX_SOCKET, ctx);
		erase_all(FPAG_CTX_SOCKET);
		print_verdict();
	end
	// Watchdog well beyond the sequence length
	initial begin
		#300000;
		error_cnt++;
		print_verdict();
	end
endmodule // tb
